// [hdl/gpb_gpio.sv]
// gpio port bank top: wishbone register file and pin control for six ports
`timescale 1ns/1ns
module gpb_gpio
  import gpb_pkg::*;
(
  // clock and reset
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  // wishbone slave
  input  wire logic                wb_cyc_in,
  input  wire logic                wb_stb_in,
  input  wire logic                wb_we_in,
  input  wire logic [9:0]          wb_adr_in,
  input  wire logic [3:0]          wb_sel_in,
  input  wire logic [31:0]         wb_dat_in,
  output logic      [31:0]         wb_dat_out,
  output logic                     wb_ack_out,
  // pins
  input  wire logic [GPB_PINS-1:0] pin_in,
  output logic      [GPB_PINS-1:0] pin_out,
  output logic      [GPB_PINS-1:0] pin_oe_out,
  output logic      [GPB_PINS-1:0] pin_pullup_out,
  // peripheral sharing
  input  wire logic [GPB_PINS-1:0] alt_en_in,
  input  wire logic [GPB_PINS-1:0] alt_out_in,
  input  wire logic [GPB_PINS-1:0] alt_oe_in,
  output logic      [GPB_PINS-1:0] pin_level_out,
  // lcd common bias on port 3
  output logic      [7:0]          lcd_com_en_out,
  output logic                     lcd_bias_third_out
);

  // one-hot port select of an index against one register column
  function automatic logic [GPB_PORTS-1:0] port_hit(
    input logic [7:0] idx,
    input logic [7:0] tbl [GPB_PORTS]
  );
    logic [GPB_PORTS-1:0] hit;
    hit = '0;
    for (int p = 0; p < GPB_PORTS; p++) begin
      hit[p] = (idx == tbl[p]);
    end
    return hit;
  endfunction

  // bus state
  gpb_bus_state_type state_r;
  gpb_bus_state_type state_nxt;

  // software registers
  logic [7:0] latch_r [GPB_PORTS];
  logic [7:0] dir_r   [GPB_PORTS];
  logic [7:0] pu_r    [GPB_PORTS];

  // flattened pin vectors
  logic [GPB_PINS-1:0] latch_flat;
  logic [GPB_PINS-1:0] dir_flat;
  logic [GPB_PINS-1:0] pu_flat;
  logic [GPB_PINS-1:0] bias_flat;
  logic [GPB_PINS-1:0] level;

  // per-port views of the synchronised levels
  logic [7:0]          level_port [GPB_PORTS];

  // bus decode
  logic                req;
  logic                wr_go;
  logic [7:0]          idx;
  logic [7:0]          wbyte;
  logic [GPB_PORTS-1:0] hit_data;
  logic [GPB_PORTS-1:0] hit_dir;
  logic [GPB_PORTS-1:0] hit_pu;
  logic                hit_lcd_en;
  logic                hit_lcd_sel;
  logic                mapped;

  // read selection
  logic [7:0]          rd_data;
  logic [7:0]          rd_dir;
  logic [7:0]          rd_pu;
  logic [7:0]          rd_byte;
  logic [31:0]         rd_word;

  // request and address decode
  assign req         = wb_cyc_in && wb_stb_in;
  assign idx         = wb_adr_in[9:2];
  assign wbyte       = wb_dat_in[7:0];
  assign hit_data    = port_hit(idx, GPB_IDX_DATA);
  assign hit_dir     = port_hit(idx, GPB_IDX_DIR);
  assign hit_pu      = port_hit(idx, GPB_IDX_PU);
  assign hit_lcd_en  = (idx == GPB_IDX_LCD_EN);
  assign hit_lcd_sel = (idx == GPB_IDX_LCD_SEL);
  assign mapped      = (|hit_data) || (|hit_dir) || (|hit_pu) || hit_lcd_en || hit_lcd_sel;

  // a write lands on the edge at which the master samples ack
  assign wr_go = (state_r == GPB_ST_ACK) && req && wb_we_in && wb_sel_in[0];

  // slave state: answer one cycle after the request, then drop ack
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      GPB_ST_IDLE: begin
        if (req) begin
          state_nxt = GPB_ST_ACK;
        end
      end
      GPB_ST_ACK: begin
        state_nxt = GPB_ST_IDLE;
      end
      default: begin
        state_nxt = GPB_ST_IDLE;
      end
    endcase
  end

  // state and ack registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r    <= GPB_ST_IDLE;
      wb_ack_out <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      wb_ack_out <= (state_r == GPB_ST_IDLE) && req;
    end
  end

  // per-port registers and pin vectors
  genvar p;
  generate
    for (p = 0; p < GPB_PORTS; p++) begin : g_port
      localparam int LSB = p * GPB_PORT_BITS;
      localparam int NB  = (p == GPB_PORTS - 1) ? (GPB_PINS - LSB) : GPB_PORT_BITS;

      // output latch, only implemented bits are kept
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          latch_r[p] <= GPB_DATA_RST;
        end else if (wr_go && hit_data[p]) begin
          latch_r[p] <= wbyte & GPB_PORT_MASK[p];
        end
      end

      // direction register, zero makes every pin an input unless a peripheral has taken it
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          dir_r[p] <= GPB_DIR_RST;
        end else if (wr_go && hit_dir[p]) begin
          dir_r[p] <= wbyte & GPB_PORT_MASK[p];
        end
      end

      // pull-up register, zero leaves inputs high-impedance
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          pu_r[p] <= GPB_PU_RST;
        end else if (wr_go && hit_pu[p]) begin
          pu_r[p] <= wbyte & GPB_PORT_MASK[p];
        end
      end

      // bit y of each register controls pin y of the port
      assign latch_flat[LSB +: NB] = latch_r[p][NB-1:0];
      assign dir_flat[LSB +: NB]   = dir_r[p][NB-1:0];
      assign pu_flat[LSB +: NB]    = pu_r[p][NB-1:0];

      // synchronised levels, absent pins read zero
      if (NB < GPB_PORT_BITS) begin : g_short
        assign level_port[p] = {{(GPB_PORT_BITS - NB){1'b0}}, level[LSB +: NB]};
      end else begin : g_full
        assign level_port[p] = level[LSB +: NB];
      end
    end
  endgenerate

  // lcd common enables and bias choice for port 3
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lcd_com_en_out     <= GPB_LCD_EN_RST;
      lcd_bias_third_out <= GPB_LCD_SEL_RST;
    end else begin
      if (wr_go && hit_lcd_en) begin
        lcd_com_en_out <= wbyte;
      end
      if (wr_go && hit_lcd_sel) begin
        lcd_bias_third_out <= wbyte[GPB_LCD_THIRD_BIT];
      end
    end
  end

  // only port 3 pins can carry an lcd bias level
  always_comb begin
    bias_flat = '0;
    bias_flat[GPB_LCD_LSB +: GPB_PORT_BITS] = lcd_com_en_out;
  end

  // read selection of the addressed port
  always_comb begin
    rd_data = 8'h00;
    rd_dir  = 8'h00;
    rd_pu   = 8'h00;
    for (int q = 0; q < GPB_PORTS; q++) begin
      if (hit_data[q]) begin
        rd_data = level_port[q];
      end
      if (hit_dir[q]) begin
        rd_dir = dir_r[q];
      end
      if (hit_pu[q]) begin
        rd_pu = pu_r[q];
      end
    end
  end

  // one byte in the low lane, unmapped reads return zero
  assign rd_byte = rd_data | rd_dir | rd_pu |
                   (hit_lcd_en ? lcd_com_en_out : 8'h00) |
                   (hit_lcd_sel ? {7'h00, lcd_bias_third_out} : 8'h00);
  assign rd_word = mapped ? {24'h000000, rd_byte} : 32'h00000000;

  // read data is captured with the ack and held while it stands
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wb_dat_out <= 32'h00000000;
    end else if ((state_r == GPB_ST_IDLE) && req && !wb_we_in) begin
      wb_dat_out <= rd_word;
    end
  end

  // pin drivers and synchronisers
  gpb_pin_bank u_bank (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .dir_in         (dir_flat),
    .pu_in          (pu_flat),
    .latch_in       (latch_flat),
    .bias_in        (bias_flat),
    .alt_en_in      (alt_en_in),
    .alt_out_in     (alt_out_in),
    .alt_oe_in      (alt_oe_in),
    .pin_in         (pin_in),
    .pin_out        (pin_out),
    .pin_oe_out     (pin_oe_out),
    .pin_pullup_out (pin_pullup_out),
    .level_out      (level)
  );

  // synchronised levels also feed the shared peripherals
  assign pin_level_out = level;

endmodule

// [hdl/gpb_pin_bank.sv]
// per-pin drivers, pull-up gating and input synchronisers for all pins
`timescale 1ns/1ns
module gpb_pin_bank
  import gpb_pkg::*;
(
  // clock and reset
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  // configuration
  input  wire logic [GPB_PINS-1:0] dir_in,
  input  wire logic [GPB_PINS-1:0] pu_in,
  input  wire logic [GPB_PINS-1:0] latch_in,
  input  wire logic [GPB_PINS-1:0] bias_in,
  // peripheral sharing
  input  wire logic [GPB_PINS-1:0] alt_en_in,
  input  wire logic [GPB_PINS-1:0] alt_out_in,
  input  wire logic [GPB_PINS-1:0] alt_oe_in,
  // pins
  input  wire logic [GPB_PINS-1:0] pin_in,
  output logic      [GPB_PINS-1:0] pin_out,
  output logic      [GPB_PINS-1:0] pin_oe_out,
  output logic      [GPB_PINS-1:0] pin_pullup_out,
  output logic      [GPB_PINS-1:0] level_out
);

  logic [GPB_PINS-1:0] sync1_r;
  logic [GPB_PINS-1:0] oe_nxt;
  logic [GPB_PINS-1:0] out_nxt;
  logic [GPB_PINS-1:0] pu_nxt;

  genvar i;
  generate
    for (i = 0; i < GPB_PINS; i++) begin : g_pin
      // peripheral takes the pin when shared, lcd bias releases the digital driver
      assign oe_nxt[i]  = bias_in[i] ? 1'b0 :
                          alt_en_in[i] ? alt_oe_in[i] : (dir_in[i] == GPB_DIR_OUTPUT);
      assign out_nxt[i] = alt_en_in[i] ? alt_out_in[i] : latch_in[i];
      // pull-up only while the pin is an input
      assign pu_nxt[i]  = pu_in[i] && !oe_nxt[i] && !bias_in[i];
    end
  endgenerate

  // registered pin drive
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_out        <= '0;
      pin_oe_out     <= '0;
      pin_pullup_out <= '0;
    end else begin
      pin_out        <= out_nxt;
      pin_oe_out     <= oe_nxt;
      pin_pullup_out <= pu_nxt;
    end
  end

  // two-stage synchroniser of the pin levels
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_r   <= '0;
      level_out <= '0;
    end else begin
      sync1_r   <= pin_in;
      level_out <= sync1_r;
    end
  end

endmodule

// [pkg/gpb_pkg.sv]
// package with register map, reset values and types for the gpio port bank
package gpb_pkg;

  // pin counts
  localparam int GPB_PORTS     = 6;
  localparam int GPB_PINS      = 46;
  localparam int GPB_PORT_BITS = 8;
  localparam int GPB_LCD_PORT  = 3;
  localparam int GPB_LCD_LSB   = 24;

  // register indexes, byte address is four times the index
  localparam logic [7:0] GPB_IDX_DATA [GPB_PORTS] = '{8'h80, 8'h90, 8'ha0, 8'hb0, 8'hc0, 8'hd8};
  localparam logic [7:0] GPB_IDX_DIR  [GPB_PORTS] = '{8'h9a, 8'h91, 8'ha1, 8'hb1, 8'hc1, 8'hd9};
  localparam logic [7:0] GPB_IDX_PU   [GPB_PORTS] = '{8'h9b, 8'h92, 8'ha2, 8'hb2, 8'hc2, 8'hda};
  localparam logic [7:0] GPB_IDX_LCD_EN  = 8'hb3;
  localparam logic [7:0] GPB_IDX_LCD_SEL = 8'hb4;

  // implemented bits of each port (port 5 has six pins)
  localparam logic [7:0] GPB_PORT_MASK [GPB_PORTS] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f};

  // reset values
  localparam logic [7:0] GPB_DATA_RST    = 8'h00;
  localparam logic [7:0] GPB_DIR_RST     = 8'h00;
  localparam logic [7:0] GPB_PU_RST      = 8'h00;
  localparam logic [7:0] GPB_LCD_EN_RST  = 8'h00;
  localparam logic       GPB_LCD_SEL_RST = 1'b0;

  // field positions and encodings
  localparam int   GPB_LCD_THIRD_BIT = 0;
  localparam logic GPB_DIR_INPUT     = 1'b0;
  localparam logic GPB_DIR_OUTPUT    = 1'b1;

  // wishbone slave states
  typedef enum logic [1:0] {
    GPB_ST_IDLE = 2'b01,
    GPB_ST_ACK  = 2'b10
  } gpb_bus_state_type;

endpackage

// [verif/gpb_gpio_sva.sv]
// concurrent checks on the gpio port bank top ports
`timescale 1ns/1ns
module gpb_gpio_sva
  import gpb_pkg::*;
(
  // clock and reset
  input wire logic                clk_in,
  input wire logic                rst_in,
  // wishbone
  input wire logic                wb_cyc_in,
  input wire logic                wb_stb_in,
  input wire logic [31:0]         wb_dat_out,
  input wire logic                wb_ack_out,
  // pins and sharing
  input wire logic [GPB_PINS-1:0] pin_in,
  input wire logic [GPB_PINS-1:0] pin_out,
  input wire logic [GPB_PINS-1:0] pin_oe_out,
  input wire logic [GPB_PINS-1:0] pin_pullup_out,
  input wire logic [GPB_PINS-1:0] alt_en_in,
  input wire logic [GPB_PINS-1:0] alt_out_in,
  input wire logic [GPB_PINS-1:0] alt_oe_in,
  input wire logic [GPB_PINS-1:0] pin_level_out,
  // lcd
  input wire logic [7:0]          lcd_com_en_out
);
  logic [1:0] up_r;
  // edges since reset release, saturating at three
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // request then a single ack pulse one edge later
  sequence req_s; $rose(wb_cyc_in && wb_stb_in); endsequence
  sequence ans_s; !wb_ack_out ##1 wb_ack_out ##1 !wb_ack_out; endsequence
  ack_answer_a: assert property (req_s |-> ans_s) else $error("ack timing wrong");
  ack_idle_a: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out) else $error("ack without request");
  dat_upper_a: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0) else $error("read upper bits set");
  reset_pins_a: assert property (up_r == 2'h0 |-> pin_oe_out == '0 && pin_pullup_out == '0)
    else $error("pins not inputs after reset");
  pu_output_a: assert property ((pin_oe_out & pin_pullup_out) == '0) else $error("pull-up on output");
  // pin drive is registered from the lcd enables, so it follows them one edge later
  lcd_off_a: assert property (((pin_oe_out[31:24] | pin_pullup_out[31:24]) & $past(lcd_com_en_out)) == 8'h0)
    else $error("lcd pin still driven");
  level_sync_a: assert property (up_r == 2'h3 |-> pin_level_out == $past(pin_in, 2))
    else $error("pin level not two stages");
  alt_take_a: assert property (up_r == 2'h3 && $stable(alt_en_in) && $stable(alt_oe_in) && $stable(alt_out_in)
    |-> (((pin_oe_out ^ alt_oe_in) | ((pin_out ^ alt_out_in) & alt_oe_in)) & alt_en_in & 46'hff_ffff) == '0)
    else $error("shared pin not handed over");
endmodule
bind gpb_gpio gpb_gpio_sva u_sva (.clk_in, .rst_in, .wb_cyc_in, .wb_stb_in, .wb_dat_out, .wb_ack_out, .pin_in,
  .pin_out, .pin_oe_out, .pin_pullup_out, .alt_en_in, .alt_out_in, .alt_oe_in, .pin_level_out, .lcd_com_en_out);

// [verif/gpb_gpio_tb.sv]
// self-checking bench for the gpio port bank
`timescale 1ns/1ns
module gpb_gpio_tb
  import gpb_pkg::*;
;
  logic                clk_in, rst_in, cyc, stb, we, ack, bias;
  logic [9:0]          adr;
  logic [3:0]          sel;
  logic [31:0]         wdat, rdat;
  logic [7:0]          q, lcd_en;
  logic [GPB_PINS-1:0] pin_w, pout, poe, ppu, lvl, alt_en, alt_out, alt_oe, ext_en, ext_val;
  int                  failures = 0, n_checks = 0;

  gpb_gpio DUT (.clk_in, .rst_in, .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .pin_in(pin_w), .pin_out(pout), .pin_oe_out(poe),
    .pin_pullup_out(ppu), .alt_en_in(alt_en), .alt_out_in(alt_out), .alt_oe_in(alt_oe), .pin_level_out(lvl),
    .lcd_com_en_out(lcd_en), .lcd_bias_third_out(bias));
  gpb_pin_model u_pins (.clk_in, .drv_in(pout), .oe_in(poe), .pu_in(ppu), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .level_out(pin_w));

  // 50 mhz clock
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task chk(input string nm, input logic [GPB_PINS-1:0] seen, input logic [GPB_PINS-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic wishbone cycle, held until ack
  task wb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s);
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= s;
    wdat <= {24'h0, d};
    // no local limit: only the watchdog ends a wait for ack
    do begin
      @(posedge clk_in);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task rd(input logic [7:0] idx);
    wb(1'b0, idx, 8'h00, 4'h1);
  endtask

  // write, then let the new configuration reach the pins
  task wr(input logic [7:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d, 4'h1);
    @(posedge clk_in);
    #1;
  endtask

  task wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog
  initial begin
    #100000;
    failures++;
    wrap_up;
  end

  initial begin
    {cyc, stb, we, adr, sel, wdat} = '0;
    {alt_en, alt_out, alt_oe, ext_en, ext_val} = '0;
    rst_in = 1'b1;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int p = 0; p < GPB_PORTS; p++) begin
      rd(GPB_IDX_DIR[p]);
      chk("dir reset", q, 0);
      rd(GPB_IDX_PU[p]);
      chk("pullup reset", q, 0);
    end
    chk("oe reset", poe, 0);
    $display("reset test done");
    // all pins push-pull outputs, as unused pins should be
    for (int p = 0; p < GPB_PORTS; p++) begin
      wr(GPB_IDX_DIR[p], 8'hff);
      wr(GPB_IDX_PU[p], 8'hff);
      wr(GPB_IDX_DATA[p], 8'ha5);
      rd(GPB_IDX_DIR[p]);
      chk("dir mask", q, GPB_PORT_MASK[p]);
      rd(GPB_IDX_PU[p]);
      chk("pullup mask", q, GPB_PORT_MASK[p]);
    end
    chk("oe all", poe, {GPB_PINS{1'b1}});
    chk("pullup off", ppu, 0);
    chk("drive", pout, {6'h25, {5{8'ha5}}});
    for (int p = 0; p < GPB_PORTS; p++) begin
      rd(GPB_IDX_DATA[p]);
      chk("out level", q, 8'ha5 & GPB_PORT_MASK[p]);
    end
    $display("output test done");
    for (int p = 0; p < GPB_PORTS; p++) wr(GPB_IDX_DIR[p], 8'h00);
    chk("pullup on", ppu, {GPB_PINS{1'b1}});
    @(posedge clk_in);
    ext_en <= 46'hff01;
    ext_val <= 46'h3c00;
    repeat (3) @(posedge clk_in);
    rd(GPB_IDX_DATA[1]);
    chk("in level", q, 8'h3c);
    rd(GPB_IDX_DATA[0]);
    chk("pulled up", q, 8'hfe);
    $display("input test done");
    wr(8'h70, 8'hff);
    rd(8'h70);
    chk("unmapped", q, 0);
    wb(1'b1, GPB_IDX_DIR[2], 8'hff, 4'h0);
    rd(GPB_IDX_DIR[2]);
    chk("no lane", q, 0);
    $display("refusal test done");
    wr(GPB_IDX_DIR[3], 8'hff);
    wr(GPB_IDX_LCD_EN, 8'h0f);
    wr(GPB_IDX_LCD_SEL, 8'h01);
    chk("lcd en", lcd_en, 8'h0f);
    chk("third", bias, 1'b1);
    chk("lcd oe", poe[31:24], 8'hf0);
    wr(GPB_IDX_LCD_SEL, 8'h00);
    chk("quarter", bias, 1'b0);
    $display("lcd test done");
    @(posedge clk_in);
    alt_en <= 46'hff0000;
    alt_oe <= 46'h0f0000;
    alt_out <= 46'h050000;
    repeat (3) @(posedge clk_in);
    #1;
    chk("alt oe", poe[23:16], 8'h0f);
    chk("alt out", pout[23:16] & 8'h0f, 8'h05);
    $display("sharing test done");
    wrap_up;
  end
endmodule

// [verif/gpb_pin_model.sv]
// board model that resolves every pin level
`timescale 1ns/1ns
module gpb_pin_model
  import gpb_pkg::*;
(
  // clock
  input  wire logic                clk_in,
  // design side
  input  wire logic [GPB_PINS-1:0] drv_in,
  input  wire logic [GPB_PINS-1:0] oe_in,
  input  wire logic [GPB_PINS-1:0] pu_in,
  // board drive
  input  wire logic [GPB_PINS-1:0] ext_en_in,
  input  wire logic [GPB_PINS-1:0] ext_val_in,
  output logic      [GPB_PINS-1:0] level_out
);
  logic [GPB_PINS-1:0] float_r = '0;
  // floating pins wander so no stale level can be read
  always @(posedge clk_in) begin
    float_r <= ~float_r;
  end
  // push-pull wins, then the board, then the pull-up
  assign level_out = (oe_in & drv_in) | (~oe_in & ext_en_in & ext_val_in)
                   | (~oe_in & ~ext_en_in & (pu_in | float_r));
endmodule
